// file: include/hmsc_pkg.sv
package hmsc_pkg;
  localparam int unsigned NUM_IRQ = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // wake latency in cpu clocks
  localparam logic [3:0] WAKE_VEC_CLKS = 4'hC;
  localparam logic [3:0] WAKE_NEXT_CLKS = 4'h4;
  localparam logic [3:0] WAKE_VEC_MIN = 4'hB;
  localparam logic [3:0] WAKE_VEC_MAX = 4'hD;
  localparam logic [3:0] WAKE_NEXT_MIN = 4'h3;
  localparam logic [3:0] WAKE_NEXT_MAX = 4'h5;
  // option byte read stall, typical figure in us
  localparam int unsigned OPT_READ_US = 544;
  localparam int unsigned OPT_READ_MIN_US = 277;
  localparam int unsigned OPT_READ_MAX_US = 1075;
  localparam int unsigned OPT_READ_CYC = (OPT_READ_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned OPT_CNT_W = 16;

  typedef enum logic [1:0] {
    HMSC_RUN,
    HMSC_HALT,
    HMSC_WAKE,
    HMSC_OPTRD
  } hmsc_state_t;

  typedef struct packed {
    logic [NUM_IRQ-1:0] req;
    logic [NUM_IRQ-1:0] mask;
    logic global_interrupt_enable_flag;
  } hmsc_irq_t;

  typedef struct packed {
    logic tm16_en;
    logic tm8a_en;
    logic tm8b_pre_en;
    logic tm8b_rl_en;
    logic adc_en;
    logic serial_en;
    logic lvd_en;
    logic extint_en;
    logic poc_en;
    logic wdt_en;
  } hmsc_periph_en_t;
endpackage

// file: rtl/hmsc_halt_ctrl.sv
`timescale 1ns/10ps
module hmsc_halt_ctrl #(
  parameter int unsigned OPT_READ_CYCLES = hmsc_pkg::OPT_READ_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic halt_exec_i,
  input wire hmsc_pkg::hmsc_irq_t irq_i,
  input wire logic opt_lsosc_stoppable_i,
  input wire logic low_speed_osc_stop_bit_i,
  input wire logic wdt_sel_lsosc_i,
  input wire logic [hmsc_pkg::PORT_W-1:0] port_latch_i,
  output logic cpu_clk_en_o,
  output logic halted_o,
  output logic wake_vector_o,
  output logic wake_next_o,
  output logic reset_vector_o,
  output logic lsosc_run_o,
  output logic wdt_cfg_err_o,
  output hmsc_pkg::hmsc_periph_en_t periph_en_o,
  output logic [hmsc_pkg::PORT_W-1:0] port_latch_o
);
  import hmsc_pkg::*;

  function automatic logic unmasked_pending(input hmsc_irq_t irq);
    unmasked_pending = |(irq.req & ~irq.mask);
  endfunction

  hmsc_state_t state_q, state_d;
  logic vec_q, vec_d;
  logic [OPT_CNT_W-1:0] opt_cnt_q, opt_cnt_d;
  logic wake_start;
  logic wake_done;
  logic pend;
  logic lsosc_run;
  logic lsosc_run_q;
  logic wv_q, wv_d, wn_q, wn_d, rv_q, rv_d;

  ////////////////////////////////////////////////////////////////
  assign pend = unmasked_pending(irq_i);
  // option byte overrides the software stop bit
  assign lsosc_run = !(opt_lsosc_stoppable_i && low_speed_osc_stop_bit_i);

  always_comb begin
    state_d = state_q;
    vec_d = vec_q;
    opt_cnt_d = opt_cnt_q;
    wake_start = 1'b0;
    wv_d = 1'b0;
    wn_d = 1'b0;
    rv_d = 1'b0;
    case (state_q)
      HMSC_OPTRD: begin
        if (opt_cnt_q == OPT_CNT_W'(OPT_READ_CYCLES - 1)) begin
          state_d = HMSC_RUN;
          rv_d = 1'b1;
        end else begin
          opt_cnt_d = opt_cnt_q + 1'b1;
        end
      end
      HMSC_RUN: begin
        if (halt_exec_i) begin
          if (pend) begin
            state_d = HMSC_RUN;
            wv_d = irq_i.global_interrupt_enable_flag;
            wn_d = !irq_i.global_interrupt_enable_flag;
          end else begin
            state_d = HMSC_HALT;
          end
        end
      end
      HMSC_HALT: begin
        if (pend) begin
          state_d = HMSC_WAKE;
          vec_d = irq_i.global_interrupt_enable_flag;
          wake_start = 1'b1;
        end
      end
      HMSC_WAKE: begin
        if (wake_done) begin
          state_d = HMSC_RUN;
          wv_d = vec_q;
          wn_d = !vec_q;
        end
      end
      default: state_d = HMSC_RUN;
    endcase
  end

  // async reset forces option read, which also ends any halt
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= HMSC_OPTRD;
      vec_q <= 1'b0;
      opt_cnt_q <= '0;
      wv_q <= 1'b0;
      wn_q <= 1'b0;
      rv_q <= 1'b0;
      lsosc_run_q <= 1'b1;
    end else begin
      state_q <= state_d;
      vec_q <= vec_d;
      opt_cnt_q <= opt_cnt_d;
      wv_q <= wv_d;
      wn_q <= wn_d;
      rv_q <= rv_d;
      lsosc_run_q <= lsosc_run;
    end
  end

  hmsc_wake_timer u_wake (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(wake_start),
    .len_i(irq_i.global_interrupt_enable_flag ? WAKE_VEC_CLKS : WAKE_NEXT_CLKS),
    .done_o(wake_done)
  );

  ////////////////////////////////////////////////////////////////
  // state outside this block is untouched; cpu clock stops, and the watchdog too unless it runs on an unstoppable oscillator
  assign cpu_clk_en_o = (state_q == HMSC_RUN);
  assign halted_o = (state_q == HMSC_HALT) || (state_q == HMSC_WAKE);
  assign wake_vector_o = wv_q;
  assign wake_next_o = wn_q;
  assign reset_vector_o = rv_q;
  assign lsosc_run_o = lsosc_run_q;
  // system clock as watchdog source is illegal when unstoppable
  assign wdt_cfg_err_o = !opt_lsosc_stoppable_i && !wdt_sel_lsosc_i;

  always_comb begin
    periph_en_o.tm16_en = 1'b1;
    periph_en_o.tm8a_en = 1'b1;
    periph_en_o.tm8b_pre_en = 1'b1;
    periph_en_o.adc_en = 1'b1;
    periph_en_o.serial_en = 1'b1;
    periph_en_o.lvd_en = 1'b1;
    periph_en_o.extint_en = 1'b1;
    periph_en_o.poc_en = 1'b1;
    periph_en_o.tm8b_rl_en = lsosc_run_q;
    // in halt the watchdog runs only on an unstoppable oscillator
    periph_en_o.wdt_en = halted_o ? (!opt_lsosc_stoppable_i && wdt_sel_lsosc_i) : 1'b1;
  end

  hmsc_port_hold u_port (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .hold_i(halted_o),
    .latch_i(port_latch_i),
    .latch_o(port_latch_o)
  );

  ////////////////////////////////////////////////////////////////
  // cycles spent in wake; still holds the full count on the edge after the pulse launches
  logic [3:0] wcnt_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wcnt_q <= 4'h0;
    end else if (state_q == HMSC_WAKE) begin
      wcnt_q <= wcnt_q + 4'h1;
    end else begin
      wcnt_q <= 4'h0;
    end
  end

  AST_ENTER: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_RUN && halt_exec_i && !pend |=> state_q == HMSC_HALT)
    else $error("halt not entered");
  AST_CANCEL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_RUN && halt_exec_i && pend |=> state_q == HMSC_RUN && (wake_vector_o || wake_next_o))
    else $error("pending request did not cancel halt");
  AST_CLKGATE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    halted_o |-> !cpu_clk_en_o)
    else $error("cpu clock running while halted");
  AST_PORT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    halted_o && $past(halted_o) |-> $stable(port_latch_o))
    else $error("port latch changed while halted");
  AST_TM8B: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    opt_lsosc_stoppable_i && low_speed_osc_stop_bit_i |=> !periph_en_o.tm8b_rl_en)
    else $error("low speed timer runs with oscillator stopped");
  AST_WDT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    halted_o && opt_lsosc_stoppable_i |-> !periph_en_o.wdt_en)
    else $error("watchdog runs in halt with stoppable oscillator");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_HALT && !pend |=> state_q == HMSC_HALT)
    else $error("halt left without unmasked request");
  AST_VEC_TIME: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(wake_vector_o) && $past(state_q) == HMSC_WAKE |->
    wcnt_q >= WAKE_VEC_MIN && wcnt_q <= WAKE_VEC_MAX)
    else $error("vectored wake latency out of range");
  AST_NEXT_TIME: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(wake_next_o) && $past(state_q) == HMSC_WAKE |->
    wcnt_q >= WAKE_NEXT_MIN && wcnt_q <= WAKE_NEXT_MAX)
    else $error("next instruction wake latency out of range");
  AST_POC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    periph_en_o.poc_en && periph_en_o.serial_en && periph_en_o.adc_en)
    else $error("always-on peripheral disabled");
  AST_OPT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_OPTRD |-> !cpu_clk_en_o)
    else $error("cpu ran during option read");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_HALT && pend |=> state_q == HMSC_WAKE)
    else $error("unmasked request did not start wake");
  AST_LSOSC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !opt_lsosc_stoppable_i |=> lsosc_run_o)
    else $error("low speed oscillator stopped while unstoppable");
  AST_WDT_ON: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    halted_o && !opt_lsosc_stoppable_i && wdt_sel_lsosc_i |-> periph_en_o.wdt_en)
    else $error("watchdog stopped in halt on unstoppable oscillator");
  AST_TIMERS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    periph_en_o.tm16_en && periph_en_o.tm8a_en && periph_en_o.tm8b_pre_en &&
    periph_en_o.lvd_en && periph_en_o.extint_en)
    else $error("timer or wake source disabled");

  COV_HALT_VEC: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(wake_vector_o));
  COV_HALT_NEXT: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(wake_next_o));
  COV_CANCEL: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_RUN && halt_exec_i && pend);
  COV_RESET_VEC: cover property (@(posedge clk_i) disable iff (!reset_n_i) reset_vector_o);
  COV_MASKED_HOLD: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == HMSC_HALT && (|irq_i.req) && !pend);
endmodule // hmsc_halt_ctrl

// file: rtl/hmsc_port_hold.sv
`timescale 1ns/10ps
module hmsc_port_hold (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hold_i,
  input wire logic [hmsc_pkg::PORT_W-1:0] latch_i,
  output logic [hmsc_pkg::PORT_W-1:0] latch_o
);
  import hmsc_pkg::*;
  logic [PORT_W-1:0] q, d;

  // freeze the latch value while held
  always_comb begin
    d = hold_i ? q : latch_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign latch_o = q;
endmodule // hmsc_port_hold

// file: rtl/hmsc_wake_timer.sv
`timescale 1ns/10ps
module hmsc_wake_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [3:0] len_i,
  output logic done_o
);
  logic [3:0] cnt_q, cnt_d;
  logic busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start_i) begin
      cnt_d = len_i - 4'h1;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 4'h0) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign done_o = busy_q && (cnt_q == 4'h0);
endmodule // hmsc_wake_timer

// file: verification/hmsc_cpu_model.sv
`timescale 1ns/10ps
module hmsc_cpu_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cpu_clk_en_i,
  input wire logic halt_req_i,
  output logic halt_exec_o
);
  // a halt only issues on a clocked cpu cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      halt_exec_o <= 1'b0;
    end else begin
      halt_exec_o <= halt_req_i & cpu_clk_en_i;
    end
  end
endmodule // hmsc_cpu_model

// file: verification/tb_halt_mode_standby_control.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t line %0d", $time, `__LINE__); end end
module tb_halt_mode_standby_control;
  import hmsc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic go = 1'b0;
  logic halt_exec;
  hmsc_irq_t irq = '0;
  logic stoppable = 1'b0;
  logic stop_bit = 1'b0;
  logic wdt_sel = 1'b1;
  logic [PORT_W-1:0] port_in = 8'h5A;
  logic cpu_en, halted, wake_vec, wake_nxt, rst_vec, ls_run, wdt_err, v1;
  hmsc_periph_en_t pen;
  logic [PORT_W-1:0] port_out;
  int miscompares = 0;
  int checks = 0;
  int n;
  always #5 clk_i = ~clk_i;
  hmsc_cpu_model u_cpu (.clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_clk_en_i(cpu_en), .halt_req_i(go),
    .halt_exec_o(halt_exec));
  // short option read keeps the run brief
  hmsc_halt_ctrl #(.OPT_READ_CYCLES(10)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .halt_exec_i(halt_exec),
    .irq_i(irq), .opt_lsosc_stoppable_i(stoppable), .low_speed_osc_stop_bit_i(stop_bit),
    .wdt_sel_lsosc_i(wdt_sel), .port_latch_i(port_in), .cpu_clk_en_o(cpu_en), .halted_o(halted),
    .wake_vector_o(wake_vec), .wake_next_o(wake_nxt), .reset_vector_o(rst_vec), .lsosc_run_o(ls_run),
    .wdt_cfg_err_o(wdt_err), .periph_en_o(pen), .port_latch_o(port_out));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_halt;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (rst_vec !== 1'b1 && n < 40);
    `CHK(n >= 10 && n <= 11, 1'b1)
    `CHK(cpu_en, 1'b1)
    `CHK(halted, 1'b0)
  endtask
  task automatic count_wake;
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (!(wake_vec | wake_nxt) && n < 40);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_vector;
    do_halt();
    `CHK(halted, 1'b1)
    `CHK(cpu_en, 1'b0)
    @(posedge clk_i);
    port_in <= 8'hA5;
    irq <= '{req: 8'h01, mask: 8'h01, global_interrupt_enable_flag: 1'b1};
    repeat (20) @(posedge clk_i);
    #1;
    `CHK(port_out, 8'h5A)
    `CHK(pen, 10'h3FF)
    `CHK(halted, 1'b1)
    @(posedge clk_i);
    irq.mask <= 8'h00;
    count_wake();
    `CHK(wake_vec, 1'b1)
    `CHK(wake_nxt, 1'b0)
    `CHK(n - 1 >= 11 && n - 1 <= 13, 1'b1)
    `CHK(cpu_en, 1'b1)
    @(posedge clk_i);
    irq <= '0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(port_out, 8'hA5)
    $display("test vector done");
  endtask
  task automatic t_next;
    do_halt();
    @(posedge clk_i);
    irq <= '{req: 8'h80, mask: 8'h7F, global_interrupt_enable_flag: 1'b0};
    count_wake();
    `CHK(wake_nxt, 1'b1)
    `CHK(wake_vec, 1'b0)
    `CHK(n - 1 >= 3 && n - 1 <= 5, 1'b1)
    $display("test next done");
  endtask
  task automatic t_pending;
    do_halt();
    v1 = wake_nxt;
    `CHK(halted, 1'b0)
    @(posedge clk_i);
    #1;
    `CHK(halted, 1'b0)
    `CHK(v1 | wake_nxt, 1'b1)
    @(posedge clk_i);
    irq <= '0;
    $display("test pending done");
  endtask
  task automatic t_osc;
    @(posedge clk_i);
    stoppable <= 1'b1;
    stop_bit <= 1'b1;
    do_halt();
    `CHK(ls_run, 1'b0)
    `CHK(pen.tm8b_rl_en, 1'b0)
    `CHK(pen.wdt_en, 1'b0)
    `CHK(pen.poc_en, 1'b1)
    // software stop bit is cleared by reset in a real part
    stop_bit <= 1'b0;
    do_reset();
    // stop bit set but ignored: oscillator is unstoppable now
    stoppable <= 1'b0;
    stop_bit <= 1'b1;
    do_halt();
    `CHK(halted, 1'b1)
    `CHK(ls_run, 1'b1)
    `CHK(pen.tm8b_rl_en, 1'b1)
    `CHK(pen.wdt_en, 1'b1)
    @(posedge clk_i);
    wdt_sel <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(wdt_err, 1'b1)
    do_reset();
    wdt_sel <= 1'b1;
    $display("test osc done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    t_vector();
    t_next();
    irq <= '{req: 8'h10, mask: 8'h00, global_interrupt_enable_flag: 1'b0};
    t_pending();
    t_osc();
    tally_and_finish();
  end
endmodule // tb_halt_mode_standby_control
